// ===== core/bmu_consts.vh
// Purpose: Constants for the single-bit manipulation unit of a 16-bit core.
// Assumes: Avalon-MM slave with byte addresses and one 32-bit word per register.
// Notes: Flag bits are C, Z, S and O in the low nibble of the flag register.
`ifndef BMU_CONSTS_VH
`define BMU_CONSTS_VH

`define BMU_OFS_CMD 8'h00
`define BMU_OFS_OPERAND 8'h04
`define BMU_OFS_BITSEL 8'h08
`define BMU_OFS_BASE 8'h0C
`define BMU_OFS_FLAGS 8'h10
`define BMU_OFS_RESULT 8'h14
`define BMU_OFS_STATUS 8'h18

`define BMU_OP_HI 3
`define BMU_OP_LO 0
`define BMU_CND_HI 7
`define BMU_CND_LO 4
`define BMU_CMD_DCARRY 8
`define BMU_CMD_MEM 9
`define BMU_CMD_W 10

`define BMU_FLG_C 0
`define BMU_FLG_Z 1
`define BMU_FLG_S 2
`define BMU_FLG_O 3
`define BMU_FLG_W 4

`define BMU_STS_BUSY 0
`define BMU_STS_DONE 1

`define BMU_RST_16 16'h0000
`define BMU_RST_32 32'h0000_0000
`define BMU_RST_CMD 10'h000
`define BMU_RST_FLG 4'h0
`define BMU_RST_8 8'h00

`define BMU_OP_CAND 4'h0
`define BMU_OP_BZERO 4'h1
`define BMU_OP_CMOVE 4'h2
`define BMU_OP_CANDN 4'h3
`define BMU_OP_CORN 4'h4
`define BMU_OP_BINV 4'h5
`define BMU_OP_BNTEST 4'h6
`define BMU_OP_CXORN 4'h7

`define BMU_CC_UGE 4'h0
`define BMU_CC_ULT 4'h1
`define BMU_CC_UGT 4'h2
`define BMU_CC_ULE 4'h3
`define BMU_CC_EQ 4'h4
`define BMU_CC_NE 4'h5
`define BMU_CC_POS 4'h6
`define BMU_CC_NEG 4'h7
`define BMU_CC_SGE 4'h8
`define BMU_CC_SLT 4'h9
`define BMU_CC_SGT 4'hA
`define BMU_CC_SLE 4'hB
`define BMU_CC_OV 4'hC
`define BMU_CC_NOV 4'hD

`define BMU_BYTE_SHIFT 3
`define BMU_BYTE_BIT_HI 2
`define BMU_WORD_BIT_HI 3

`endif

// ===== core/bmu_core.v
// Purpose: Single-bit datapath: clear, invert, conditional move, carry logic, inverted test.
// Assumes: Avalon-MM slave port; simple memory port with a level strobe held until ack.
// Notes: A command write starts one operation; commands written while busy are ignored.
//
// Implementation choices: register access over Avalon-MM and the register offsets.
`timescale 1ns/10ps
`include "bmu_consts.vh"

module bmu_core (
  input wire clk_i,
  input wire rst_i,
  input wire [7:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0] avs_byteenable_i,
  output reg [31:0] avs_readdata_o,
  output reg avs_waitrequest_o,
  output reg [15:0] mem_addr_o,
  output reg mem_rd_o,
  output reg mem_wr_o,
  output reg [7:0] mem_wdata_o,
  input wire [7:0] mem_rdata_i,
  input wire mem_ack_i,
  output reg [3:0] flags_o,
  output reg done_o
);

  // Binary state codes; register operands skip both memory states.
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_MRD = 2'b01;
  localparam [1:0] ST_EXEC = 2'b10;
  localparam [1:0] ST_MWR = 2'b11;

  reg [1:0] state_ff;
  reg [9:0] cmd_ff;
  reg [15:0] operand_ff;
  reg [15:0] bitsel_ff;
  reg [15:0] base_ff;
  reg [15:0] result_ff;
  reg [7:0] mbyte_ff;
  reg start_ff;
  reg sts_done_ff;

  // Flag taps read the live flag register, so a software write counts at once.
  wire wr_acc;
  wire rd_acc;
  wire busy;
  wire [3:0] op;
  wire is_mem;
  wire dcarry;
  wire fc;
  wire fz;
  wire fs;
  wire fo;
  wire [15:0] bit_hit;

  // Combinational terms of the datapath; none of these hold state.
  reg [31:0] nxt_rdata;
  reg [15:0] work;
  reg [3:0] idx;
  reg src;
  reg cond_hold;
  reg [15:0] nxt_word;
  reg [3:0] nxt_flags;
  reg writes_bit;
  reg new_bit;

  // A write takes effect only at the edge where waitrequest is seen low; rd_acc marks the earlier request edge.
  assign wr_acc = avs_write_i && !avs_waitrequest_o;
  assign rd_acc = avs_read_i && avs_waitrequest_o;
  assign busy = (state_ff != ST_IDLE) || start_ff;
  assign op = cmd_ff[`BMU_OP_HI:`BMU_OP_LO];
  assign is_mem = cmd_ff[`BMU_CMD_MEM];
  assign dcarry = cmd_ff[`BMU_CMD_DCARRY];
  assign fc = flags_o[`BMU_FLG_C];
  assign fz = flags_o[`BMU_FLG_Z];
  assign fs = flags_o[`BMU_FLG_S];
  assign fo = flags_o[`BMU_FLG_O];

  // Partial writes keep the untouched byte lane, as the byte enables ask.
  function [15:0] merge16;
    input [15:0] old;
    input [15:0] wdat;
    input [1:0] be;
    begin
      merge16 = old;
      if (be[0]) begin
        merge16[7:0] = wdat[7:0];
      end
      if (be[1]) begin
        merge16[15:8] = wdat[15:8];
      end
    end
  endfunction

  // Reads have no side effect, so software may poll status while an operation runs.
  always @* begin
    nxt_rdata = `BMU_RST_32;
    case (avs_address_i)
      `BMU_OFS_CMD: nxt_rdata[`BMU_CMD_W-1:0] = cmd_ff;
      `BMU_OFS_OPERAND: nxt_rdata[15:0] = operand_ff;
      `BMU_OFS_BITSEL: nxt_rdata[15:0] = bitsel_ff;
      `BMU_OFS_BASE: nxt_rdata[15:0] = base_ff;
      `BMU_OFS_FLAGS: nxt_rdata[`BMU_FLG_W-1:0] = flags_o;
      `BMU_OFS_RESULT: nxt_rdata[15:0] = result_ff;
      `BMU_OFS_STATUS: begin
        nxt_rdata[`BMU_STS_BUSY] = busy;
        nxt_rdata[`BMU_STS_DONE] = sts_done_ff;
      end
      default: nxt_rdata = `BMU_RST_32;
    endcase
  end

  // Memory bits live in bytes, so the offset splits into a byte step and a bit within it.
  always @* begin
    if (is_mem) begin
      work = {`BMU_RST_8, mbyte_ff};
      idx = {1'b0, bitsel_ff[`BMU_BYTE_BIT_HI:0]};
    end else begin
      work = operand_ff;
      idx = bitsel_ff[`BMU_WORD_BIT_HI:0];
    end
    src = work[idx];
  end

  // A decoded select per bit makes the write-back a mask and merge; no other bit can move.
  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1) begin : g_bit_sel
      localparam [3:0] BIT_POS = g;
      assign bit_hit[g] = (idx == BIT_POS);
    end
  endgenerate

  // Codes 14 and 15 are spare and read false, so a stray code only ever writes zero.
  always @* begin
    case (cmd_ff[`BMU_CND_HI:`BMU_CND_LO])
      `BMU_CC_UGE: cond_hold = fc;
      `BMU_CC_ULT: cond_hold = !fc;
      `BMU_CC_UGT: cond_hold = fc && !fz;
      `BMU_CC_ULE: cond_hold = !(fc && !fz);
      `BMU_CC_EQ: cond_hold = fz;
      `BMU_CC_NE: cond_hold = !fz;
      `BMU_CC_OV: cond_hold = fo;
      `BMU_CC_NOV: cond_hold = !fo;
      `BMU_CC_POS: cond_hold = !fs;
      `BMU_CC_NEG: cond_hold = fs;
      `BMU_CC_SGE: cond_hold = !(fs ^ fo);
      `BMU_CC_SLT: cond_hold = fs ^ fo;
      `BMU_CC_SGT: cond_hold = !((fs ^ fo) || fz);
      `BMU_CC_SLE: cond_hold = (fs ^ fo) || fz;
      default: cond_hold = 1'b0;
    endcase
  end

  // Every path starts from the unchanged word and flags so untouched bits stay put.
  always @* begin
    nxt_word = work;
    nxt_flags = flags_o;
    writes_bit = 1'b0;
    new_bit = 1'b0;
    case (op)
      `BMU_OP_CAND: nxt_flags[`BMU_FLG_C] = fc & src;
      `BMU_OP_BZERO: begin
        new_bit = 1'b0;
        writes_bit = 1'b1;
      end
      `BMU_OP_CMOVE: begin
        if (dcarry) begin
          nxt_flags[`BMU_FLG_C] = cond_hold;
        end else begin
          new_bit = cond_hold;
          writes_bit = 1'b1;
        end
      end
      `BMU_OP_CANDN: nxt_flags[`BMU_FLG_C] = fc & !src;
      `BMU_OP_CORN: nxt_flags[`BMU_FLG_C] = fc | !src;
      `BMU_OP_BINV: begin
        new_bit = !src;
        writes_bit = 1'b1;
      end
      `BMU_OP_BNTEST: begin
        nxt_flags[`BMU_FLG_Z] = !src;
        nxt_flags[`BMU_FLG_C] = !src;
      end
      `BMU_OP_CXORN: nxt_flags[`BMU_FLG_C] = fc ^ !src;
      default: nxt_flags = flags_o;
    endcase

    if (writes_bit) begin
      nxt_word = (work & ~bit_hit) | ({16{new_bit}} & bit_hit);
    end
  end

  // Read data load on the request edge, so they already stand when waitrequest drops.
  always @(posedge clk_i) begin
    if (rst_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= `BMU_RST_32;
    end else begin
      // One wait cycle per access, then a single ready edge.
      avs_waitrequest_o <= !((avs_read_i || avs_write_i) && avs_waitrequest_o);
      if (rd_acc) begin
        avs_readdata_o <= nxt_rdata;
      end
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= ST_IDLE;
      cmd_ff <= `BMU_RST_CMD;
      operand_ff <= `BMU_RST_16;
      bitsel_ff <= `BMU_RST_16;
      base_ff <= `BMU_RST_16;
      result_ff <= `BMU_RST_16;
      mbyte_ff <= `BMU_RST_8;
      flags_o <= `BMU_RST_FLG;
      start_ff <= 1'b0;
      sts_done_ff <= 1'b0;
      done_o <= 1'b0;
      mem_addr_o <= `BMU_RST_16;
      mem_rd_o <= 1'b0;
      mem_wr_o <= 1'b0;
      mem_wdata_o <= `BMU_RST_8;
    end else begin
      start_ff <= 1'b0;
      done_o <= 1'b0;

      // Operand and selector writes are blocked while busy so a running operation stays coherent.
      if (wr_acc && !busy) begin
        case (avs_address_i)
          `BMU_OFS_CMD: begin
            if (avs_byteenable_i[0] && avs_byteenable_i[1]) begin
              cmd_ff <= avs_writedata_i[`BMU_CMD_W-1:0];
              start_ff <= 1'b1;
              sts_done_ff <= 1'b0;
            end
          end
          `BMU_OFS_OPERAND: operand_ff <= merge16(operand_ff, avs_writedata_i[15:0],
                                                  avs_byteenable_i[1:0]);
          `BMU_OFS_BITSEL: bitsel_ff <= merge16(bitsel_ff, avs_writedata_i[15:0],
                                                avs_byteenable_i[1:0]);
          `BMU_OFS_BASE: base_ff <= merge16(base_ff, avs_writedata_i[15:0],
                                            avs_byteenable_i[1:0]);
          `BMU_OFS_FLAGS: begin
            if (avs_byteenable_i[0]) begin
              flags_o <= avs_writedata_i[`BMU_FLG_W-1:0];
            end
          end
          default: start_ff <= 1'b0;
        endcase
      end

      // The memory strobes stay up until acknowledged, so a slow memory only stretches the op.
      case (state_ff)
        ST_IDLE: begin
          if (start_ff) begin
            if (is_mem) begin
              mem_addr_o <= base_ff + (bitsel_ff >> `BMU_BYTE_SHIFT);
              mem_rd_o <= 1'b1;
              state_ff <= ST_MRD;
            end else begin
              state_ff <= ST_EXEC;
            end
          end
        end
        ST_MRD: begin
          if (mem_ack_i) begin
            mem_rd_o <= 1'b0;
            mbyte_ff <= mem_rdata_i;
            state_ff <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          // Flags and result move on one edge, so a status poll never sees half an update.
          flags_o <= nxt_flags;
          result_ff <= nxt_word;
          if (is_mem && writes_bit) begin
            mem_wdata_o <= nxt_word[7:0];
            mem_wr_o <= 1'b1;
            state_ff <= ST_MWR;
          end else begin
            done_o <= 1'b1;
            sts_done_ff <= 1'b1;
            state_ff <= ST_IDLE;
          end
        end
        ST_MWR: begin
          // Done waits for the write acknowledge, so software never reads a stale byte.
          if (mem_ack_i) begin
            mem_wr_o <= 1'b0;
            done_o <= 1'b1;
            sts_done_ff <= 1'b1;
            state_ff <= ST_IDLE;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

endmodule // bmu_core

// ===== test/bmu_core_properties.sv
// Purpose: Port checks of the bit manipulation unit.
// Assumes: One wait cycle on every bus access.
// Notes: Bound to every instance of the core.
`timescale 1ns/10ps
module bmu_core_properties (
  input wire clk_i,
  input wire rst_i,
  input wire [7:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire avs_waitrequest_o,
  input wire [31:0] avs_readdata_o,
  input wire [15:0] mem_addr_o,
  input wire mem_rd_o,
  input wire mem_wr_o,
  input wire [7:0] mem_wdata_o,
  input wire mem_ack_i,
  input wire [3:0] flags_o,
  input wire done_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_wait_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o) else $error("No answer to request.");
  a_wait_idle: assert property (!avs_read_i && !avs_write_i |=> avs_waitrequest_o)
    else $error("Answer without request.");
  a_wait_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("Answer longer than one cycle.");
  a_unmapped_zero: assert property (avs_read_i && avs_waitrequest_o && avs_address_i == 8'h20
    |=> avs_readdata_o == 32'h0000_0000) else $error("Unmapped read not zero.");
  a_done_pulse: assert property (done_o |=> !done_o) else $error("Done too long.");
  a_rd_hold: assert property (mem_rd_o && !mem_ack_i |=> mem_rd_o && $stable(mem_addr_o))
    else $error("Read strobe dropped early.");
  a_wr_hold: assert property (mem_wr_o && !mem_ack_i
    |=> mem_wr_o && $stable(mem_wdata_o)) else $error("Write strobe dropped early.");
  a_wr_addr: assert property (mem_wr_o && !mem_ack_i |=> $stable(mem_addr_o))
    else $error("Write address moved.");
  a_flags_cause: assert property (!$stable(flags_o) |-> done_o ||
    $past(avs_write_i && !avs_waitrequest_o && avs_address_i == 8'h10))
    else $error("Flags moved without an operation or a write.");
  a_strobe_excl: assert property (!(mem_rd_o && mem_wr_o)) else $error("Both strobes high.");
  a_write_noflag: assert property ($rose(mem_wr_o) |-> $stable(flags_o))
    else $error("Flags moved on bit write.");
endmodule // bmu_core_properties
bind bmu_core bmu_core_properties u_props (.clk_i(clk_i), .rst_i(rst_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_waitrequest_o(avs_waitrequest_o), .avs_readdata_o(avs_readdata_o),
  .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o),
  .mem_wdata_o(mem_wdata_o), .mem_ack_i(mem_ack_i), .flags_o(flags_o), .done_o(done_o));

// ===== test/bmu_mem_model.sv
// Purpose: Memory partner answering the unit's byte strobes.
// Assumes: Wait states follow the low two address bits.
// Notes: Read data toggle while no answer is given.
`timescale 1ns/10ps
module bmu_mem_model (
  input wire clk_i,
  input wire [15:0] addr_i,
  input wire rd_i,
  input wire wr_i,
  input wire [7:0] wdata_i,
  output logic [7:0] rdata_o,
  output logic ack_o
);
  logic [7:0] mem [0:255];
  int w;
  initial begin
    for (w = 0; w < 256; w++) mem[w] = w[7:0] ^ 8'h5A;
    w = 0;
    ack_o = 1'b0;
    rdata_o = 8'h00;
  end
  // Stale data keep changing, so a unit that samples early reads garbage.
  always @(posedge clk_i) begin
    ack_o <= 1'b0;
    rdata_o <= ~rdata_o;
    if ((rd_i || wr_i) && !ack_o) begin
      if (w < int'(addr_i[1:0])) w <= w + 1;
      else begin
        w <= 0;
        ack_o <= 1'b1;
        if (wr_i) mem[addr_i[7:0]] <= wdata_i;
        else rdata_o <= mem[addr_i[7:0]];
      end
    end
  end
endmodule // bmu_mem_model

// ===== test/test_bit_manipulation_unit.sv
// Purpose: Self-checking bench of the bit manipulation unit.
// Assumes: Memory partner adds zero to three wait cycles.
// Notes: Reads queue their expectation; a monitor compares.
`timescale 1ns/10ps
`include "bmu_consts.vh"
module test_bit_manipulation_unit;
  logic clk_i, rst_i, avs_read_i, avs_write_i;
  logic [7:0] avs_address_i;
  logic [31:0] avs_writedata_i;
  wire [31:0] avs_readdata_o;
  wire avs_waitrequest_o, mem_rd_o, mem_wr_o, mem_ack_i, done_o;
  wire [15:0] mem_addr_o;
  wire [7:0] mem_wdata_o, mem_rdata_i;
  wire [3:0] flags_o;
  logic [31:0] exp_q[$];
  logic [3:0] flag_q[$];
  logic [15:0] r, q;
  int fails, n_tests, i;
  bmu_core uut (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(4'hF), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o),
    .mem_wr_o(mem_wr_o), .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i),
    .mem_ack_i(mem_ack_i), .flags_o(flags_o), .done_o(done_o));
  bmu_mem_model m (.clk_i(clk_i), .addr_i(mem_addr_o), .rd_i(mem_rd_o), .wr_i(mem_wr_o),
    .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i), .ack_o(mem_ack_i));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  function automatic [15:0] lf(input [15:0] x);
    lf = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  function automatic [19:0] calc(input [3:0] o, cd, input dc, input [3:0] f,
    input [15:0] w, input [3:0] b);
    logic c, z, s, v;
    logic [15:0] cv;
    c = f[0];
    z = f[1];
    s = w[b];
    v = f[2] ^ f[3];
    cv = {2'b00, ~f[3], f[3], v | z, ~(v | z), v, ~v, f[2], ~f[2], ~z, z,
      ~(c & ~z), c & ~z, ~c, c};
    case (o)
      0: c = c & s;
      1: w[b] = 1'b0;
      2: if (dc) c = cv[cd]; else w[b] = cv[cd];
      3: c = c & ~s;
      4: c = c | ~s;
      5: w[b] = ~s;
      6: begin z = ~s; c = ~s; end
      default: c = c ^ ~s;
    endcase
    calc = {f[3:2], z, c, w};
  endfunction
  task report_and_stop;
    $display("Counts: tests=%0d fails=%0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task chk(input [31:0] g, e);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  always @(posedge clk_i) if (avs_read_i && avs_waitrequest_o === 1'b0)
    chk(avs_readdata_o, exp_q.pop_front());
  // Each done pulse carries the flags of the oldest queued operation.
  always @(posedge clk_i) if (done_o === 1'b1)
    chk({28'h000_0000, flags_o}, {28'h000_0000, flag_q.pop_front()});
  // The request stays up until the edge that sees the answer.
  task bus(input rd, input [7:0] a, input [31:0] d);
    int k;
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_read_i <= rd;
    avs_write_i <= !rd;
    for (k = 0; k < 20; k++) begin
      @(posedge clk_i);
      if (avs_waitrequest_o === 1'b0) break;
    end
    if (k == 20) begin fails++; report_and_stop(); end
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task rd(input [7:0] a, input [31:0] e);
    exp_q.push_back(e);
    bus(1'b1, a, 32'h0000_0000);
  endtask
  task op(input [3:0] o, cd, input dc, mm, input [15:0] w, bs, ba, input [3:0] f);
    logic [15:0] a;
    logic [19:0] e;
    int k;
    a = ba + (bs >> 3);
    bus(1'b0, `BMU_OFS_FLAGS, {28'h000_0000, f});
    bus(1'b0, `BMU_OFS_OPERAND, {16'h0000, w});
    bus(1'b0, `BMU_OFS_BITSEL, {16'h0000, bs});
    bus(1'b0, `BMU_OFS_BASE, {16'h0000, ba});
    if (mm) e = calc(o, cd, dc, f, {8'h00, m.mem[a[7:0]]}, {1'b0, bs[2:0]});
    else e = calc(o, cd, dc, f, w, bs[3:0]);
    flag_q.push_back(e[19:16]);
    bus(1'b0, `BMU_OFS_CMD, {22'h00_0000, mm, dc, cd, o});
    for (k = 0; k < 60; k++) begin
      @(posedge clk_i);
      if (done_o === 1'b1) break;
    end
    if (k == 60) begin fails++; report_and_stop(); end
    rd(`BMU_OFS_RESULT, {16'h0000, e[15:0]});
    rd(`BMU_OFS_FLAGS, {28'h000_0000, e[19:16]});
    rd(`BMU_OFS_STATUS, 32'h0000_0002);
    if (mm) chk({24'h00_0000, m.mem[a[7:0]]}, {24'h00_0000, e[7:0]});
  endtask
  initial begin
    rst_i = 1'b1;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_address_i = 8'h00;
    avs_writedata_i = 32'h0000_0000;
    r = 16'h0002;
    fails = 0;
    n_tests = 0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (i = 0; i < 8; i++) rd(8'(i * 4), 32'h0000_0000);
    bus(1'b0, 8'h20, 32'hFFFF_FFFF);
    rd(8'h20, 32'h0000_0000);
    // Later passes go to memory, where only the low four codes of the condition are used.
    for (i = 0; i < 160; i++) begin
      r = lf(r);
      q = lf(r);
      op({1'b0, i[2:0]}, i[6:3], (i[2:0] == 3'd2) & r[0], i >= 128, q, {8'h00, r[15:8]},
        {8'h00, r[7:0]}, r[3:0] ^ q[7:4]);
    end
    report_and_stop();
  end
endmodule // test_bit_manipulation_unit
